// ### core/llsc_pkg.sv
// Summary of operation
// RQ1: Line loop returns recovered receive stream to transmit.
// RQ2: Software sets at most one timing/loop mode.
// RQ3: Parallel loop feeds transmit data into receive.
// RQ4: Twisted-pair loop uses raw line receiver stream.
// RQ5: Fixed pointer mode holds pointer at 522.
// RQ6: Delineation loss after 4ms alarm-free out-of-delineation.
// RQ7: Delineation loss clears after 4ms of sync.
// RQ8: Delineation-loss changes interrupt when enabled.
// RQ9: Transmit synthesizer unlocked beyond 488 ppm.
// RQ10: Transmit unlock flag set on change, read clears.
// RQ11: Transmit unlock enable gates its interrupt.
// RQ12: Receive data unlocked: 488 ppm or 80 quiet bits.
// RQ13: Receive reference unlock follows recovery lock.
// RQ14: Software polls reference unlock before trusting recovery.
// RQ15: Receive data unlock flag set on change, read clears.
// RQ16: Receive reference unlock flag set on change, read clears.
// RQ17: Receive lock enables gate their interrupts.
// RQ18: Quiet mode puts transmit outputs in balanced idle.
// RQ19: Output enable low floats transmit outputs; resets high.
// RQ20: Reference select chooses internal or external reference.
// RQ21: Software writes zero to synthesis reserved bits.
// RQ22: Software writes line config reserved bits at defaults.
// RQ23: Loop timing uses recovered clock while data locked.
// RQ24: Interrupt output low while enabled flag pending.
// RQ25: Event during clearing read keeps flag set.
package llsc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IRQ_SUMMARY = 8'h02;
  localparam logic [7:0] IDX_MASTER_CTRL = 8'h05;
  localparam logic [7:0] IDX_TX_SYNTH    = 8'h06;
  localparam logic [7:0] IDX_RX_LOCK     = 8'h08;
  localparam logic [7:0] IDX_RX_CFG      = 8'h09;
  localparam logic [7:0] IDX_LTX_CFG1    = 8'h0A;
  localparam logic [7:0] IDX_LTX_CFG2    = 8'h0B;
  localparam logic [7:0] IDX_LRX_CFG     = 8'h0C;

  // Writable register slots: index, writable bit mask and reset value.
  localparam int NUM_SLOTS = 7;
  localparam logic [7:0] SLOT_IDX   [NUM_SLOTS] =
    '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
  localparam logic [7:0] SLOT_WMASK [NUM_SLOTS] =
    '{8'hBF, 8'h83, 8'h87, 8'h07, 8'hBF, 8'hFF, 8'h7F};
  localparam logic [7:0] SLOT_RESET [NUM_SLOTS] =
    '{8'h20, 8'h00, 8'h00, 8'h07, 8'h2C, 8'hFF, 8'h01};
  localparam int SLOT_MASTER = 0;
  localparam int SLOT_TX     = 1;
  localparam int SLOT_RX     = 2;
  localparam int SLOT_RXCFG  = 3;
  localparam int SLOT_LTX1   = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_LCD_IRQ_EN    = 7;
  localparam int B_LCD_STATE     = 6;
  localparam int B_FIXED_PTR     = 5;
  localparam int B_PAIR_LOOP     = 4;
  localparam int B_PAR_LOOP      = 3;
  localparam int B_LINE_LOOP     = 2;
  localparam int B_SERIAL_LOOP   = 1;
  localparam int B_LOOP_TIMING   = 0;
  localparam int B_TX_IRQ        = 5;
  localparam int B_TX_STATE      = 3;
  localparam int B_TX_IRQ_EN     = 1;
  localparam int B_RXR_IRQ       = 6;
  localparam int B_RXD_IRQ       = 5;
  localparam int B_RXR_STATE     = 4;
  localparam int B_RXD_STATE     = 3;
  localparam int B_RXR_IRQ_EN    = 2;
  localparam int B_RXD_IRQ_EN    = 1;
  localparam int B_VREF_SEL      = 7;
  localparam int B_TX_OUT_EN     = 5;
  localparam int B_TX_QUIET      = 4;
  localparam int B_SUM_SYNTH     = 7;
  localparam int B_SUM_LCD       = 6;
  localparam int B_SUM_RECOV     = 5;

  // ----------------------------------------------------------------
  // Timing and values
  // ----------------------------------------------------------------
  localparam int MCLK_FREQ_HZ     = 40_000_000;
  localparam int LCD_TIME_US      = 4000;
  localparam int LCD_HOLD_CYC     = LCD_TIME_US * (MCLK_FREQ_HZ / 1_000_000);
  localparam int PPM_LIMIT        = 488;
  localparam int MON_WINDOW_DEF   = 8192;
  localparam int NO_TRANS_BITS    = 80;
  localparam int PTR_W            = 10;
  localparam logic [9:0] FIXED_PTR_VALUE = 10'h20A;

  // Bus phase tracking.
  typedef enum logic [2:0] {
    BS_IDLE   = 3'b001,
    BS_WRWAIT = 3'b010,
    BS_WRDONE = 3'b100
  } llsc_bus_t;

endpackage

// ### core/llsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module llsc_top #(
  parameter int LCD_HOLD_CYCLES = llsc_pkg::LCD_HOLD_CYC,
  parameter int MON_WINDOW      = llsc_pkg::MON_WINDOW_DEF
) (
  // Clock and reset.
  input  wire logic                      MCLK,
  input  wire logic                      RESETN,
  // AHB-Lite slave.
  input  wire logic                      HSEL,
  input  wire logic [31:0]               HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [31:0]               HWDATA,
  input  wire logic                      HREADY,
  output logic [31:0]                    HRDATA,
  output logic                           HREADYOUT,
  output logic                           HRESP,
  // Clock monitor strobes, one cycle each, and the reference lock level.
  input  wire logic                      REF_CLK_TICK,
  input  wire logic                      SYNTH_CLK_TICK,
  input  wire logic                      RECOV_CLK_TICK,
  input  wire logic                      RX_BIT_TICK,
  input  wire logic                      RX_LINE_EDGE,
  input  wire logic                      RX_REF_LOCKED,
  // Cell delineation and alarm levels.
  input  wire logic                      CELL_OUT_OF_DELIN,
  input  wire logic                      CELL_SYNC,
  input  wire logic                      ALM_SIGNAL_LOSS,
  input  wire logic                      ALM_POINTER_LOSS,
  input  wire logic                      ALM_PATH_AIS,
  input  wire logic                      ALM_LINE_AIS,
  // Serial data paths.
  input  wire logic                      RX_LINE_BIT,
  input  wire logic                      RX_RECOV_BIT,
  input  wire logic                      TX_SER_BIT,
  output logic                           TX_LINE_BIT,
  output logic                           TX_LINE_OE,
  output logic                           TX_QUIET,
  // Parallel data paths.
  input  wire logic [7:0]                TX_PAR_DATA,
  input  wire logic [7:0]                RX_PAR_IN,
  output logic [7:0]                     RX_PAR_DATA,
  // Pointer and timing control.
  input  wire logic [llsc_pkg::PTR_W-1:0] TX_PTR_CTRL,
  output logic [llsc_pkg::PTR_W-1:0]     TX_PTR_VALUE,
  output logic                           TX_PTR_FIXED,
  output logic                           TX_CLK_FROM_RECOV,
  output logic                           SERIAL_DIAG_LOOP,
  output logic                           VREF_EXT_SEL,
  output logic [2:0]                     RECOV_CFG,
  // Shared interrupt.
  output logic                           IRQ_N
);
  import llsc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int PPM_TOL = (MON_WINDOW * PPM_LIMIT) / 1_000_000;
  localparam int MW      = $clog2(2 * MON_WINDOW + 2);
  localparam int LW      = $clog2(LCD_HOLD_CYCLES + 1);

  if (LCD_HOLD_CYCLES < 2) begin : g_chk_lcd
    $error("LCD_HOLD_CYCLES must be at least 2.");
  end
  if (MON_WINDOW < 4096 || MON_WINDOW > 65536) begin : g_chk_win
    $error("MON_WINDOW must lie between 4096 and 65536.");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  llsc_bus_t            bus_state;
  llsc_bus_t            next_bus_state;
  logic [7:0]           ctl [NUM_SLOTS];
  logic [29:0]          wr_idx;
  logic                 lcd_state;
  logic                 next_lcd_state;
  logic                 tx_state;
  logic                 rxd_state;
  logic                 rxr_state;
  logic                 lcd_irq;
  logic                 tx_irq;
  logic                 rxd_irq;
  logic                 rxr_irq;

  wire logic            acc      = HSEL & HTRANS[1] & HREADY;
  wire logic            rd_acc   = acc & ~HWRITE;
  wire logic            wr_acc   = acc & HWRITE;
  wire logic            wr_now   = (bus_state == BS_WRWAIT);
  wire logic            rd_sum   = rd_acc & (HADDR[31:2] == {22'h0, IDX_IRQ_SUMMARY});
  wire logic            rd_tx    = rd_acc & (HADDR[31:2] == {22'h0, IDX_TX_SYNTH});
  wire logic            rd_rx    = rd_acc & (HADDR[31:2] == {22'h0, IDX_RX_LOCK});

  // Writes take one wait state so a following read sees the new value.
  assign HREADYOUT = (bus_state != BS_WRWAIT);
  assign HRESP     = 1'b0;

  always_comb begin
    next_bus_state = BS_IDLE;
    unique case (bus_state)
      BS_IDLE, BS_WRDONE: begin
        next_bus_state = wr_acc ? BS_WRWAIT : BS_IDLE;
      end
      BS_WRWAIT: begin
        next_bus_state = BS_WRDONE;
      end
    endcase
  end

  // Bus phase register and captured write index.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_state <= BS_IDLE;
      wr_idx    <= 30'h0;
    end else begin
      bus_state <= next_bus_state;
      if (wr_acc) begin
        wr_idx <= HADDR[31:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable slots with status overlay
  // ----------------------------------------------------------------
  logic [7:0] ovl   [NUM_SLOTS];
  logic [7:0] chain [NUM_SLOTS+1];

  assign ovl[SLOT_MASTER] = {1'b0, lcd_state, 6'h00};
  assign ovl[SLOT_TX]     = {2'b00, tx_irq, 1'b0, tx_state, 3'b000};
  assign ovl[SLOT_RX]     = {1'b0, rxr_irq, rxd_irq, rxr_state, rxd_state, 3'b000};
  assign ovl[3]           = 8'h00;
  assign ovl[4]           = 8'h00;
  assign ovl[5]           = 8'h00;
  assign ovl[6]           = 8'h00;
  assign chain[0]         = {lcd_irq, 7'h00} >> (B_SUM_SYNTH - B_SUM_LCD) |
                            {(tx_irq & ctl[SLOT_TX][B_TX_IRQ_EN]), 7'h00} |
                            {2'b00, ((rxd_irq & ctl[SLOT_RX][B_RXD_IRQ_EN]) |
                                     (rxr_irq & ctl[SLOT_RX][B_RXR_IRQ_EN])), 5'h00};

  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    wire logic hit_rd = (HADDR[31:2] == {22'h0, SLOT_IDX[i]});
    wire logic hit_wr = wr_now & (wr_idx == {22'h0, SLOT_IDX[i]});
    // Read mux: summary value only survives when the summary index is hit.
    assign chain[i+1] = (i == 0 ? (rd_sum ? chain[0] : 8'h00) : chain[i]) |
                        (hit_rd ? ((ctl[i] & SLOT_WMASK[i]) | ovl[i]) : 8'h00);

    // Only writable bits take bus data; reserved ones keep their stored value but read back as zero or status.
    always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
        ctl[i] <= SLOT_RESET[i];
      end else if (hit_wr) begin
        ctl[i] <= (HWDATA[7:0] & SLOT_WMASK[i]) | (ctl[i] & ~SLOT_WMASK[i]);
      end
    end
  end

  // Read data is registered at the address phase; unmapped reads give zero.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      HRDATA <= 32'h0;
    end else if (rd_acc) begin
      HRDATA <= {24'h0, chain[NUM_SLOTS]};
    end
  end

  // ----------------------------------------------------------------
  // Frequency monitors: channel 0 synthesizer, channel 1 recovery
  // ----------------------------------------------------------------
  logic [1:0] mon_unlock;
  wire  logic [1:0] mon_tick = {RECOV_CLK_TICK, SYNTH_CLK_TICK};

  for (genvar k = 0; k < 2; k++) begin : g_mon
    logic [MW-1:0] ref_cnt;
    logic [MW-1:0] meas_cnt;
    wire  logic [MW-1:0] meas_inc = meas_cnt + MW'(mon_tick[k]);
    wire  logic    win_end  = REF_CLK_TICK & (ref_cnt == MW'(MON_WINDOW - 1));
    // Unlocked when the count misses the window by more than the tolerance.
    wire  logic    off_freq = (meas_inc > MW'(MON_WINDOW + PPM_TOL)) |
                              ((meas_inc + MW'(PPM_TOL)) < MW'(MON_WINDOW));

    always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
        ref_cnt       <= '0;
        meas_cnt      <= '0;
        mon_unlock[k] <= 1'b0;
      end else if (win_end) begin
        ref_cnt       <= '0;
        meas_cnt      <= '0;
        mon_unlock[k] <= off_freq;  // RQ9 RQ12
      end else begin
        ref_cnt  <= ref_cnt + MW'(REF_CLK_TICK);
        meas_cnt <= (meas_cnt == '1) ? meas_cnt : meas_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive line transition watchdog
  // ----------------------------------------------------------------
  logic [6:0] quiet_bits;
  wire  logic no_trans = (quiet_bits > 7'(NO_TRANS_BITS));

  // Counts bit periods since the last line transition, saturating.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      quiet_bits <= 7'h00;
    end else if (RX_LINE_EDGE) begin
      quiet_bits <= 7'h00;
    end else if (RX_BIT_TICK && !no_trans) begin
      quiet_bits <= quiet_bits + 7'h01;  // RQ12
    end
  end

  // ----------------------------------------------------------------
  // Lock states and change-detect interrupt flags
  // ----------------------------------------------------------------
  wire logic next_tx_state  = mon_unlock[0];                  // RQ9
  wire logic next_rxd_state = mon_unlock[1] | no_trans;       // RQ12
  wire logic next_rxr_state = ~RX_REF_LOCKED;                 // RQ13

  // Status levels; reference unlock reads high after reset until locked.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_state  <= 1'b0;
      rxd_state <= 1'b0;
      rxr_state <= 1'b1;
    end else begin
      tx_state  <= next_tx_state;
      rxd_state <= next_rxd_state;
      rxr_state <= next_rxr_state;  // RQ13
    end
  end

  // Flags set on any change; a change in the clearing cycle wins.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_irq  <= 1'b0;
      rxd_irq <= 1'b0;
      rxr_irq <= 1'b0;
      lcd_irq <= 1'b0;
    end else begin
      tx_irq  <= (tx_irq & ~rd_tx) | (next_tx_state ^ tx_state);     // RQ10 RQ25
      rxd_irq <= (rxd_irq & ~rd_rx) | (next_rxd_state ^ rxd_state);  // RQ15 RQ25
      rxr_irq <= (rxr_irq & ~rd_rx) | (next_rxr_state ^ rxr_state);  // RQ16 RQ25
      lcd_irq <= (lcd_irq & ~rd_sum) | (next_lcd_state ^ lcd_state); // RQ8 RQ25
    end
  end

  // ----------------------------------------------------------------
  // Loss of cell delineation
  // ----------------------------------------------------------------
  logic [LW-1:0] lcd_cnt;
  wire  logic    lcd_alarm   = ALM_SIGNAL_LOSS | ALM_POINTER_LOSS | ALM_PATH_AIS | ALM_LINE_AIS;
  wire  logic    lcd_qual    = lcd_state ? CELL_SYNC : (CELL_OUT_OF_DELIN & ~lcd_alarm);
  wire  logic    lcd_expire  = lcd_qual & (lcd_cnt == LW'(LCD_HOLD_CYCLES - 1));

  // The state flips only after the qualifying condition held unbroken.
  assign next_lcd_state = lcd_expire ? ~lcd_state : lcd_state;  // RQ6 RQ7

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      lcd_cnt   <= '0;
      lcd_state <= 1'b0;
    end else begin
      lcd_cnt   <= (lcd_qual && !lcd_expire) ? lcd_cnt + LW'(1) : '0;  // RQ6 RQ7
      lcd_state <= next_lcd_state;
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt output
  // ----------------------------------------------------------------
  wire logic irq_any = (lcd_irq & ctl[SLOT_MASTER][B_LCD_IRQ_EN]) |  // RQ8
                       (tx_irq  & ctl[SLOT_TX][B_TX_IRQ_EN])      |  // RQ11
                       (rxd_irq & ctl[SLOT_RX][B_RXD_IRQ_EN])     |  // RQ17
                       (rxr_irq & ctl[SLOT_RX][B_RXR_IRQ_EN]);       // RQ17

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ_N <= 1'b1;
    end else begin
      IRQ_N <= ~irq_any;  // RQ24
    end
  end

  // ----------------------------------------------------------------
  // Loopbacks and line data paths
  // ----------------------------------------------------------------
  wire logic pair_loop = ctl[SLOT_MASTER][B_PAIR_LOOP];
  wire logic line_loop = ctl[SLOT_MASTER][B_LINE_LOOP];
  wire logic par_loop  = ctl[SLOT_MASTER][B_PAR_LOOP];

  // Twisted-pair loop takes the raw receiver bit, line loop the recovered one.
  wire logic tx_bit_sel = pair_loop ? RX_LINE_BIT :   // RQ4
                          line_loop ? RX_RECOV_BIT :  // RQ1
                          TX_SER_BIT;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_LINE_BIT <= 1'b0;
      RX_PAR_DATA <= 8'h00;
    end else begin
      TX_LINE_BIT <= tx_bit_sel;
      RX_PAR_DATA <= par_loop ? TX_PAR_DATA : RX_PAR_IN;  // RQ3
    end
  end

  // Transmit output stage, reference and recovery configuration.
  assign TX_LINE_OE       = ctl[SLOT_LTX1][B_TX_OUT_EN]; // RQ19
  assign TX_QUIET         = ctl[SLOT_LTX1][B_TX_QUIET];  // RQ18
  assign VREF_EXT_SEL     = ctl[SLOT_LTX1][B_VREF_SEL];  // RQ20
  assign RECOV_CFG        = ctl[SLOT_RXCFG][2:0];
  assign SERIAL_DIAG_LOOP = ctl[SLOT_MASTER][B_SERIAL_LOOP];

  // Loop timing falls back to the reference when data lock is lost.
  assign TX_CLK_FROM_RECOV = ctl[SLOT_MASTER][B_LOOP_TIMING] & ~rxd_state;  // RQ23

  // Pointer generation.
  assign TX_PTR_FIXED = ctl[SLOT_MASTER][B_FIXED_PTR];
  assign TX_PTR_VALUE = TX_PTR_FIXED ? FIXED_PTR_VALUE : TX_PTR_CTRL;  // RQ5

endmodule // llsc_top
`default_nettype wire

// ### verification/llsc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module llsc_chk (
  // Clock, reset and bus.
  input wire logic                        MCLK,
  input wire logic                        RESETN,
  input wire logic                        HSEL,
  input wire logic [1:0]                  HTRANS,
  input wire logic                        HWRITE,
  input wire logic                        HREADY,
  input wire logic [31:0]                 HRDATA,
  input wire logic                        HREADYOUT,
  input wire logic                        HRESP,
  // Data paths and line settings.
  input wire logic                        RX_LINE_BIT,
  input wire logic                        RX_RECOV_BIT,
  input wire logic                        TX_SER_BIT,
  input wire logic                        TX_LINE_BIT,
  input wire logic [7:0]                  TX_PAR_DATA,
  input wire logic [7:0]                  RX_PAR_IN,
  input wire logic [7:0]                  RX_PAR_DATA,
  input wire logic [llsc_pkg::PTR_W-1:0]  TX_PTR_CTRL,
  input wire logic [llsc_pkg::PTR_W-1:0]  TX_PTR_VALUE,
  input wire logic                        TX_PTR_FIXED,
  input wire logic                        TX_LINE_OE,
  input wire logic                        TX_QUIET,
  input wire logic                        VREF_EXT_SEL,
  input wire logic                        IRQ_N
);
  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // A transfer is taken when selected, non-idle and the bus is ready.
  wire take = HSEL & HTRANS[1] & HREADY;
  sequence s_wr_data;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  a_rd_no_wait: assert property (take && !HWRITE |=> HREADYOUT)
    else $error("read data phase stalled");
  a_wr_one_wait: assert property (take && HWRITE |=> s_wr_data)
    else $error("write data phase not one wait cycle");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  a_rdata_upper: assert property (HRDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  // ------------------------------------------------------------
  // Line outputs
  // ------------------------------------------------------------
  a_ptr_fixed: assert property (TX_PTR_FIXED |-> TX_PTR_VALUE == 10'h20A)
    else $error("fixed pointer not 522");
  a_ptr_follow: assert property (!TX_PTR_FIXED |-> TX_PTR_VALUE == TX_PTR_CTRL)
    else $error("pointer does not follow control");
  a_reset_values: assert property ($rose(RESETN) |->
    TX_LINE_OE && !TX_QUIET && !VREF_EXT_SEL && IRQ_N)
    else $error("wrong line settings after reset");
  a_par_source: assert property ($past(RESETN) |->
    RX_PAR_DATA == $past(TX_PAR_DATA) || RX_PAR_DATA == $past(RX_PAR_IN))
    else $error("receive parallel data from no source");
  a_line_source: assert property ($past(RESETN) |->
    TX_LINE_BIT == $past(RX_LINE_BIT) || TX_LINE_BIT == $past(RX_RECOV_BIT) ||
    TX_LINE_BIT == $past(TX_SER_BIT))
    else $error("transmit line bit from no source");
endmodule // llsc_chk
bind llsc_top llsc_chk u_chk (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .RX_LINE_BIT(RX_LINE_BIT), .RX_RECOV_BIT(RX_RECOV_BIT), .TX_SER_BIT(TX_SER_BIT),
  .TX_LINE_BIT(TX_LINE_BIT), .TX_PAR_DATA(TX_PAR_DATA), .RX_PAR_IN(RX_PAR_IN),
  .RX_PAR_DATA(RX_PAR_DATA), .TX_PTR_CTRL(TX_PTR_CTRL), .TX_PTR_VALUE(TX_PTR_VALUE),
  .TX_PTR_FIXED(TX_PTR_FIXED), .TX_LINE_OE(TX_LINE_OE), .TX_QUIET(TX_QUIET),
  .VREF_EXT_SEL(VREF_EXT_SEL), .IRQ_N(IRQ_N));
`default_nettype wire

// ### verification/test_loopback_lock_status_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_loopback_lock_status_control;
  import llsc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        mclk = 1'b0, resetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        tick_q = 1'b0, synth_on = 1'b1, edge_on = 1'b1, ref_locked = 1'b0;
  logic        ood = 1'b0, sync = 1'b0, rx_line = 1'b1, rx_recov = 1'b0, tx_ser = 1'b1;
  logic [3:0]  alm = 4'h0;
  logic        tx_line, tx_oe, tx_quiet, tx_fixed, clk_recov, serial_loop, vref_ext, irq_n;
  logic [7:0]  tx_par = 8'hA5, rx_in = 8'h3C, rx_par;
  logic [9:0]  ptr_ctrl = 10'h155, ptr_val;
  logic [2:0]  recov_cfg;
  int          err_count = 0, check_count = 0, cyc = 0;
  // Monitor strobes share one half-rate tick so all clocks look locked.
  llsc_top #(.LCD_HOLD_CYCLES(20), .MON_WINDOW(4096)) dut (.MCLK(mclk), .RESETN(resetn),
    .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .REF_CLK_TICK(tick_q), .SYNTH_CLK_TICK(tick_q & synth_on), .RECOV_CLK_TICK(tick_q),
    .RX_BIT_TICK(tick_q), .RX_LINE_EDGE(tick_q & edge_on), .RX_REF_LOCKED(ref_locked),
    .CELL_OUT_OF_DELIN(ood), .CELL_SYNC(sync), .ALM_SIGNAL_LOSS(alm[0]),
    .ALM_POINTER_LOSS(alm[1]), .ALM_PATH_AIS(alm[2]), .ALM_LINE_AIS(alm[3]),
    .RX_LINE_BIT(rx_line), .RX_RECOV_BIT(rx_recov), .TX_SER_BIT(tx_ser), .TX_LINE_BIT(tx_line),
    .TX_LINE_OE(tx_oe), .TX_QUIET(tx_quiet), .TX_PAR_DATA(tx_par), .RX_PAR_IN(rx_in),
    .RX_PAR_DATA(rx_par), .TX_PTR_CTRL(ptr_ctrl), .TX_PTR_VALUE(ptr_val),
    .TX_PTR_FIXED(tx_fixed), .TX_CLK_FROM_RECOV(clk_recov), .SERIAL_DIAG_LOOP(serial_loop),
    .VREF_EXT_SEL(vref_ext), .RECOV_CFG(recov_cfg), .IRQ_N(irq_n));
  // Clock, strobe and timeout.
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    tick_q <= ~tick_q;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Ready and read data are taken at the rising edge, before the design updates them.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] ex);
    xfer(1'b0, idx, 8'h00);
    `CHK("register", {24'h0, ex}, rd)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] ix [9] = '{8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    logic [7:0] ex [9] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h10, 8'h07, 8'h2C, 8'hFF, 8'h01};
    foreach (ix[i]) rdchk(ix[i], ex[i]);
    `CHK("rcfg", 3'h7, recov_cfg)
  endtask
  task automatic t_line_cfg();
    xfer(1'b1, IDX_LTX_CFG1, 8'h9C);
    `CHK("oe", 1'b0, tx_oe)
    `CHK("quiet", 1'b1, tx_quiet)
    `CHK("vref", 1'b1, vref_ext)
    rdchk(IDX_LTX_CFG1, 8'h9C);
    xfer(1'b1, 8'h07, 8'h55);
    rdchk(8'h07, 8'h00);
    xfer(1'b1, IDX_LTX_CFG1, 8'h2C);
    `CHK("oe", 1'b1, tx_oe)
    `CHK("quiet", 1'b0, tx_quiet)
    `CHK("vref", 1'b0, vref_ext)
  endtask
  task automatic t_paths();
    logic [7:0] m [7] = '{8'h10, 8'h14, 8'h04, 8'h00, 8'h08, 8'h20, 8'h02};
    foreach (m[i]) begin
      tx_ser <= !m[i][4];
      xfer(1'b1, IDX_MASTER_CTRL, m[i]);
      tick(2);
      `CHK("fixed", m[i][5], tx_fixed)
      `CHK("line", (m[i][4] | !m[i][2]), tx_line)
      `CHK("par", (m[i][3] ? tx_par : rx_in), rx_par)
      `CHK("ptr", (m[i][5] ? 10'h20A : ptr_ctrl), ptr_val)
      `CHK("sdiag", m[i][1], serial_loop)
    end
  endtask
  task automatic t_lcd();
    xfer(1'b1, IDX_MASTER_CTRL, 8'hA0);
    ood <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      alm <= 4'h1 << i;
      tick(30);
      rdchk(IDX_MASTER_CTRL, 8'hA0);
    end
    alm <= 4'h0;
    tick(12);
    rdchk(IDX_MASTER_CTRL, 8'hA0);
    tick(12);
    rdchk(IDX_MASTER_CTRL, 8'hE0);
    `CHK("irq", 1'b0, irq_n)
    xfer(1'b0, IDX_IRQ_SUMMARY, 8'h00);
    `CHK("lcd flag", 1'b1, rd[6])
    tick(1);
    `CHK("irq", 1'b1, irq_n)
    ood <= 1'b0;
    sync <= 1'b1;
    tick(12);
    rdchk(IDX_MASTER_CTRL, 8'hE0);
    tick(12);
    rdchk(IDX_MASTER_CTRL, 8'hA0);
    `CHK("irq", 1'b0, irq_n)
    xfer(1'b1, IDX_MASTER_CTRL, 8'h20);
    sync <= 1'b0;
    ood <= 1'b1;
    tick(40);
    `CHK("irq", 1'b1, irq_n)
  endtask
  task automatic t_rx();
    xfer(1'b1, IDX_RX_LOCK, 8'h06);
    xfer(1'b1, IDX_MASTER_CTRL, 8'h21);
    `CHK("loop clk", 1'b1, clk_recov)
    edge_on <= 1'b0;
    tick(200);
    `CHK("irq", 1'b0, irq_n)
    `CHK("loop clk", 1'b0, clk_recov)
    rdchk(IDX_RX_LOCK, 8'h3E);
    tick(1);
    `CHK("irq", 1'b1, irq_n)
    ref_locked <= 1'b1;
    tick(3);
    `CHK("irq", 1'b0, irq_n)
    rdchk(IDX_RX_LOCK, 8'h4E);
    rdchk(IDX_RX_LOCK, 8'h0E);
    edge_on <= 1'b1;
    tick(4);
    rdchk(IDX_RX_LOCK, 8'h26);
    `CHK("loop clk", 1'b1, clk_recov)
    xfer(1'b1, IDX_RX_LOCK, 8'h00);
  endtask
  task automatic t_tx();
    xfer(1'b1, IDX_TX_SYNTH, 8'h02);
    synth_on <= 1'b0;
    tick(17000);
    `CHK("irq", 1'b0, irq_n)
    rdchk(IDX_TX_SYNTH, 8'h2A);
    rdchk(IDX_TX_SYNTH, 8'h0A);
    tick(1);
    `CHK("irq", 1'b1, irq_n)
    xfer(1'b1, IDX_TX_SYNTH, 8'h00);
    synth_on <= 1'b1;
    tick(17000);
    `CHK("irq", 1'b1, irq_n)
    rdchk(IDX_TX_SYNTH, 8'h20);
  endtask
  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_line_cfg();
    t_paths();
    t_lcd();
    t_rx();
    t_tx();
    test_done();
  end
endmodule // test_loopback_lock_status_control
`default_nettype wire
